//--- hdl/profile_cfg_pkg.sv
// Constants, byte layouts and output carrier of the reference profile configuration bank
// -----------------------------------------------------------------------------
// Summary of operation
// - Promoted priority applies while reference active
// - Selection priority ranks reference among others
// - Forty-bit period in fs, five bytes
// - Validation and redetect timers, 16-bit ms
// - Coefficient is linear times power of two
// - Linear part fraction, exponent part integer
// - Input divide ratio is value plus one
// - Feedback ratio value plus one, minimum eight
// - Phase lock threshold 16-bit picoseconds
// - Frequency lock threshold 24-bit, three bytes
// - Phase lock fill and drain bytes
// - Frequency lock fill and drain bytes
// -----------------------------------------------------------------------------
package profile_cfg_pkg;

  // ---------------------------------------------------------------------------
  // Bus geometry
  // ---------------------------------------------------------------------------
  localparam int ADR_W  = 16;
  localparam int DAT_W  = 32;
  localparam int SEL_W  = 4;
  localparam int IDX_W  = 14;
  localparam int BYTE_W = 8;

  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [BYTE_W-1:0] byte_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DAT_W-1:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic             ack;
    logic [DAT_W-1:0] dat;
  } wb_rsp_t;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam idx_t OFF_PRIO       = 14'h0632;
  localparam idx_t OFF_PERIOD     = 14'h0633;
  localparam idx_t OFF_PERIOD_TOP = 14'h0637;
  localparam idx_t OFF_PAD_LO     = 14'h0638;
  localparam idx_t OFF_PAD_HI     = 14'h0639;
  localparam idx_t OFF_INNER      = 14'h063a;
  localparam idx_t OFF_INNER_TOP  = 14'h063c;
  localparam idx_t OFF_OUTER      = 14'h063d;
  localparam idx_t OFF_OUTER_TOP  = 14'h063f;
  localparam idx_t OFF_VALID      = 14'h0640;
  localparam idx_t OFF_VALID_TOP  = 14'h0641;
  localparam idx_t OFF_REDET      = 14'h0642;
  localparam idx_t OFF_A0         = 14'h0644;
  localparam idx_t OFF_A12        = 14'h0646;
  localparam idx_t OFF_B0A2       = 14'h0647;
  localparam idx_t OFF_B0_MID     = 14'h0648;
  localparam idx_t OFF_B1B0       = 14'h0649;
  localparam idx_t OFF_G0         = 14'h064a;
  localparam idx_t OFF_G1G0       = 14'h064c;
  localparam idx_t OFF_D0_LO      = 14'h064d;
  localparam idx_t OFF_D1D0       = 14'h064e;
  localparam idx_t OFF_A3D1       = 14'h064f;
  localparam idx_t OFF_RDIV       = 14'h0650;
  localparam idx_t OFF_RDIV_TOP   = 14'h0653;
  localparam idx_t OFF_SDIV       = 14'h0654;
  localparam idx_t OFF_SDIV_TOP   = 14'h0656;
  localparam idx_t OFF_SDIV_PAD   = 14'h0657;
  localparam idx_t OFF_FRAC_LO    = 14'h0658;
  localparam idx_t OFF_FRAC_MID   = 14'h0659;
  localparam idx_t OFF_FRAC_HI    = 14'h065a;
  localparam idx_t OFF_PLOCK      = 14'h065b;
  localparam idx_t OFF_PFILL      = 14'h065d;
  localparam idx_t OFF_PDRAIN     = 14'h065e;
  localparam idx_t OFF_FLOCK      = 14'h065f;
  localparam idx_t OFF_FFILL      = 14'h0662;
  localparam idx_t OFF_FDRAIN     = 14'h0663;

  // Byte counts of the little-endian fields
  localparam int PERIOD_N = 5;
  localparam int TOL_N    = 3;
  localparam int TIMER_N  = 2;
  localparam int RDIV_N   = 4;
  localparam int SDIV_N   = 3;
  localparam int PLOCK_N  = 2;
  localparam int FLOCK_N  = 3;
  localparam int WIDE_W   = 40;

  // ---------------------------------------------------------------------------
  // Field widths and limits
  // ---------------------------------------------------------------------------
  localparam int PRIO_W = 3;
  localparam int PERIOD_W = 40;
  localparam int TOL_W = 20;
  localparam int TIMER_W = 16;
  localparam int A0_W = 16;
  localparam int A1_W = 6;
  localparam int A2_W = 3;
  localparam int A3_W = 4;
  localparam int B0_W = 17;
  localparam int B1_W = 5;
  localparam int G0_W = 17;
  localparam int G1_W = 5;
  localparam int D0_W = 15;
  localparam int D1_W = 5;
  localparam int RDIV_W = 30;
  localparam int SDIV_W = 20;
  localparam int FRAC_W = 10;
  localparam int PLOCK_W = 16;
  localparam int FLOCK_W = 24;
  localparam logic [SDIV_W-1:0] SDIV_MIN = 20'h00007;

  // Write masks: zero bits are unused and never stored
  localparam byte_t MASK_FULL = 8'hff;
  localparam byte_t MASK_NONE = 8'h00;
  localparam byte_t MASK_LOW6 = 8'h3f;
  localparam byte_t MASK_LOW7 = 8'h7f;
  localparam byte_t MASK_NIB  = 8'h0f;
  localparam byte_t MASK_FRAC = 8'hf3;
  localparam byte_t RESET_BYTE = 8'h00;

  // ---------------------------------------------------------------------------
  // Layouts of bytes that hold parts of several fields
  // ---------------------------------------------------------------------------
  typedef struct packed {logic [1:0] rsvd; logic [2:0] promoted; logic [2:0] select;} prio_byte_t;
  typedef struct packed {logic [1:0] a2_lo; logic [5:0] a1;} a12_byte_t;
  typedef struct packed {logic [6:0] b0_lo; logic a2_hi;} b0a2_byte_t;
  typedef struct packed {logic rsvd; logic [4:0] b1; logic [1:0] b0_hi;} b1b0_byte_t;
  typedef struct packed {logic [1:0] rsvd; logic [4:0] g1; logic g0_hi;} g1g0_byte_t;
  typedef struct packed {logic d1_lo; logic [6:0] d0_hi;} d1d0_byte_t;
  typedef struct packed {logic [3:0] a3; logic [3:0] d1_hi;} a3d1_byte_t;
  typedef struct packed {logic [3:0] u_lo; logic [1:0] rsvd; logic [1:0] v_hi;} frac_mid_byte_t;
  typedef struct packed {logic [1:0] rsvd; logic [5:0] u_hi;} frac_hi_byte_t;

  // Every stored field of the profile, as seen by the loop and monitors
  typedef struct packed {
    logic [PRIO_W-1:0]   promoted_prio;
    logic [PRIO_W-1:0]   select_prio;
    logic [PERIOD_W-1:0] period_fs;
    logic [TOL_W-1:0]    inner_tol;
    logic [TOL_W-1:0]    outer_tol;
    logic [TIMER_W-1:0]  validation_ms;
    logic [TIMER_W-1:0]  redetect_ms;
    logic [A0_W-1:0]     alpha0_lin;
    logic [A1_W-1:0]     alpha1_exp;
    logic [A2_W-1:0]     alpha2_exp;
    logic [A3_W-1:0]     alpha3_exp;
    logic [B0_W-1:0]     beta0_lin;
    logic [B1_W-1:0]     beta1_exp;
    logic [G0_W-1:0]     gamma0_lin;
    logic [G1_W-1:0]     gamma1_exp;
    logic [D0_W-1:0]     delta0_lin;
    logic [D1_W-1:0]     delta1_exp;
    logic [RDIV_W-1:0]   input_div;
    logic [SDIV_W-1:0]   feedback_int;
    logic [FRAC_W-1:0]   frac_num;
    logic [FRAC_W-1:0]   frac_den;
    logic [PLOCK_W-1:0]  phase_thresh_ps;
    byte_t               phase_fill;
    byte_t               phase_drain;
    logic [FLOCK_W-1:0]  freq_thresh;
    byte_t               freq_fill;
    byte_t               freq_drain;
  } profile_cfg_t;

  // Which bits of each byte are stored
  function automatic byte_t byte_mask(idx_t a);
    byte_t m;
    case (a)
      OFF_PRIO:                              m = MASK_LOW6;
      OFF_PAD_LO, OFF_PAD_HI, OFF_SDIV_PAD:  m = MASK_NONE;
      OFF_INNER_TOP, OFF_OUTER_TOP:          m = MASK_NIB;
      OFF_SDIV_TOP:                          m = MASK_NIB;
      OFF_B1B0:                              m = MASK_LOW7;
      OFF_G1G0, OFF_RDIV_TOP, OFF_FRAC_HI:   m = MASK_LOW6;
      OFF_FRAC_MID:                          m = MASK_FRAC;
      default:                               m = MASK_FULL;
    endcase
    return m;
  endfunction

endpackage

//--- hdl/cfg_byte.sv
// One masked configuration byte with synchronous reset
`timescale 1ns/10ps
module cfg_byte #(
  parameter profile_cfg_pkg::byte_t MASK = profile_cfg_pkg::MASK_FULL
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   wr,
  input  wire profile_cfg_pkg::byte_t d,
  output profile_cfg_pkg::byte_t      q
);

  // Unused positions never take a one, so they read back as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      q <= profile_cfg_pkg::RESET_BYTE;
    end else if (wr) begin
      q <= d & MASK;
    end
  end

endmodule

//--- hdl/reference_profile_config_bank.sv
// Wishbone register bank holding one reference profile of the clock synchronizer
`timescale 1ns/10ps
module reference_profile_config_bank (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire profile_cfg_pkg::wb_req_t      wb_req,
  output profile_cfg_pkg::wb_rsp_t           wb_rsp,
  input  wire logic                          ref_active,
  output profile_cfg_pkg::profile_cfg_t      cfg,
  output logic [profile_cfg_pkg::PRIO_W-1:0] effective_prio,
  output logic [profile_cfg_pkg::RDIV_W:0]   input_ratio,
  output logic [profile_cfg_pkg::SDIV_W:0]   feedback_ratio,
  output logic                               prio_order_bad,
  output logic                               feedback_too_small
);

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  profile_cfg_pkg::idx_t  req_idx;
  logic                   req_live;
  logic                   mapped;
  logic                   wr_fire;
  profile_cfg_pkg::byte_t regs [profile_cfg_pkg::OFF_PRIO:profile_cfg_pkg::OFF_FDRAIN];
  profile_cfg_pkg::byte_t next_rd;

  // Word-aligned index; misaligned or out-of-range words read zero
  assign req_idx  = wb_req.adr[profile_cfg_pkg::ADR_W-1:2];
  assign req_live = wb_req.cyc && wb_req.stb;
  assign mapped   = (wb_req.adr[1:0] == 2'h0)
                    && (req_idx >= profile_cfg_pkg::OFF_PRIO)
                    && (req_idx <= profile_cfg_pkg::OFF_FDRAIN);
  // Writes land on the edge where ack is seen, only with lane 0 enabled
  assign wr_fire  = req_live && wb_req.we && wb_rsp.ack && wb_req.sel[0] && mapped;

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  // One masked byte per index; the mask table drops unused bits
  for (genvar g = profile_cfg_pkg::OFF_PRIO; g <= profile_cfg_pkg::OFF_FDRAIN; g++) begin : g_byte
    cfg_byte #(
      .MASK (profile_cfg_pkg::byte_mask(profile_cfg_pkg::idx_t'(g)))
    ) u_byte (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .wr      (wr_fire && (req_idx == profile_cfg_pkg::idx_t'(g))),
      .d       (wb_req.dat[profile_cfg_pkg::BYTE_W-1:0]),
      .q       (regs[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Bus answer
  // ---------------------------------------------------------------------------
  // Read mux; anything unmapped answers zero rather than an error
  always_comb begin
    next_rd = profile_cfg_pkg::RESET_BYTE;
    if (mapped) begin
      next_rd = regs[req_idx];
    end
  end

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_rsp.ack <= 1'b0;
    end else begin
      wb_rsp.ack <= req_live && !wb_rsp.ack;
    end
  end

  // Read data captured together with ack, cleared otherwise
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wb_rsp.dat <= '0;
    end else if (req_live && !wb_rsp.ack && !wb_req.we) begin
      wb_rsp.dat <= {{(profile_cfg_pkg::DAT_W-profile_cfg_pkg::BYTE_W){1'b0}}, next_rd};
    end else begin
      wb_rsp.dat <= '0;
    end
  end

  // ---------------------------------------------------------------------------
  // Field assembly
  // ---------------------------------------------------------------------------
  // Gather n bytes least significant first; masked bytes pad with zero
  function automatic logic [profile_cfg_pkg::WIDE_W-1:0] le_bytes(
    input profile_cfg_pkg::idx_t base,
    input int                    n
  );
    logic [profile_cfg_pkg::WIDE_W-1:0] v;
    v = '0;
    for (int i = 0; i < profile_cfg_pkg::PERIOD_N; i++) begin
      if (i < n) begin
        v[i*profile_cfg_pkg::BYTE_W +: profile_cfg_pkg::BYTE_W] =
          regs[base + profile_cfg_pkg::idx_t'(i)];
      end
    end
    return v;
  endfunction

  profile_cfg_pkg::prio_byte_t     prio_b;
  profile_cfg_pkg::a12_byte_t      a12_b;
  profile_cfg_pkg::b0a2_byte_t     b0a2_b;
  profile_cfg_pkg::b1b0_byte_t     b1b0_b;
  profile_cfg_pkg::g1g0_byte_t     g1g0_b;
  profile_cfg_pkg::d1d0_byte_t     d1d0_b;
  profile_cfg_pkg::a3d1_byte_t     a3d1_b;
  profile_cfg_pkg::frac_mid_byte_t fmid_b;
  profile_cfg_pkg::frac_hi_byte_t  fhi_b;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_period;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_inner;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_outer;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_valid;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_redet;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_rdiv;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_sdiv;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_plock;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_flock;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_alpha0;
  logic [profile_cfg_pkg::WIDE_W-1:0] w_gamma0;

  // Byte views of the shared bytes
  assign prio_b = regs[profile_cfg_pkg::OFF_PRIO];
  assign a12_b  = regs[profile_cfg_pkg::OFF_A12];
  assign b0a2_b = regs[profile_cfg_pkg::OFF_B0A2];
  assign b1b0_b = regs[profile_cfg_pkg::OFF_B1B0];
  assign g1g0_b = regs[profile_cfg_pkg::OFF_G1G0];
  assign d1d0_b = regs[profile_cfg_pkg::OFF_D1D0];
  assign a3d1_b = regs[profile_cfg_pkg::OFF_A3D1];
  assign fmid_b = regs[profile_cfg_pkg::OFF_FRAC_MID];
  assign fhi_b  = regs[profile_cfg_pkg::OFF_FRAC_HI];

  // Little-endian multi-byte fields; a process rather than assigns, so
  // the byte flops read inside the function wake it up
  always_comb begin
    w_period = le_bytes(profile_cfg_pkg::OFF_PERIOD, profile_cfg_pkg::PERIOD_N);
    w_inner  = le_bytes(profile_cfg_pkg::OFF_INNER, profile_cfg_pkg::TOL_N);
    w_outer  = le_bytes(profile_cfg_pkg::OFF_OUTER, profile_cfg_pkg::TOL_N);
    w_valid  = le_bytes(profile_cfg_pkg::OFF_VALID, profile_cfg_pkg::TIMER_N);
    w_redet  = le_bytes(profile_cfg_pkg::OFF_REDET, profile_cfg_pkg::TIMER_N);
    w_rdiv   = le_bytes(profile_cfg_pkg::OFF_RDIV, profile_cfg_pkg::RDIV_N);
    w_sdiv   = le_bytes(profile_cfg_pkg::OFF_SDIV, profile_cfg_pkg::SDIV_N);
    w_plock  = le_bytes(profile_cfg_pkg::OFF_PLOCK, profile_cfg_pkg::PLOCK_N);
    w_flock  = le_bytes(profile_cfg_pkg::OFF_FLOCK, profile_cfg_pkg::FLOCK_N);
    w_alpha0 = le_bytes(profile_cfg_pkg::OFF_A0, profile_cfg_pkg::TIMER_N);
    w_gamma0 = le_bytes(profile_cfg_pkg::OFF_G0, profile_cfg_pkg::TIMER_N);
  end

  // Parallel view of every stored field; the pad bytes hold nothing
  always_comb begin
    cfg               = '0;
    cfg.promoted_prio = prio_b.promoted;
    cfg.select_prio   = prio_b.select;
    cfg.period_fs     = w_period[profile_cfg_pkg::PERIOD_W-1:0];
    cfg.inner_tol     = w_inner[profile_cfg_pkg::TOL_W-1:0];
    cfg.outer_tol     = w_outer[profile_cfg_pkg::TOL_W-1:0];
    cfg.validation_ms = w_valid[profile_cfg_pkg::TIMER_W-1:0];
    cfg.redetect_ms   = w_redet[profile_cfg_pkg::TIMER_W-1:0];
    // Linear parts are unsigned fractions below one, exponents integers
    cfg.alpha0_lin    = w_alpha0[profile_cfg_pkg::A0_W-1:0];
    cfg.alpha1_exp    = a12_b.a1;
    cfg.alpha2_exp    = {b0a2_b.a2_hi, a12_b.a2_lo};
    cfg.alpha3_exp    = a3d1_b.a3;
    cfg.beta0_lin     = {b1b0_b.b0_hi, regs[profile_cfg_pkg::OFF_B0_MID], b0a2_b.b0_lo};
    cfg.beta1_exp     = b1b0_b.b1;
    cfg.gamma0_lin    = {g1g0_b.g0_hi, w_gamma0[profile_cfg_pkg::G0_W-2:0]};
    cfg.gamma1_exp    = g1g0_b.g1;
    cfg.delta0_lin    = {d1d0_b.d0_hi, regs[profile_cfg_pkg::OFF_D0_LO]};
    cfg.delta1_exp    = {a3d1_b.d1_hi, d1d0_b.d1_lo};
    cfg.input_div     = w_rdiv[profile_cfg_pkg::RDIV_W-1:0];
    cfg.feedback_int  = w_sdiv[profile_cfg_pkg::SDIV_W-1:0];
    cfg.frac_den      = {fmid_b.v_hi, regs[profile_cfg_pkg::OFF_FRAC_LO]};
    cfg.frac_num      = {fhi_b.u_hi, fmid_b.u_lo};
    cfg.phase_thresh_ps = w_plock[profile_cfg_pkg::PLOCK_W-1:0];
    cfg.phase_fill    = regs[profile_cfg_pkg::OFF_PFILL];
    cfg.phase_drain   = regs[profile_cfg_pkg::OFF_PDRAIN];
    cfg.freq_thresh   = w_flock[profile_cfg_pkg::FLOCK_W-1:0];
    cfg.freq_fill     = regs[profile_cfg_pkg::OFF_FFILL];
    cfg.freq_drain    = regs[profile_cfg_pkg::OFF_FDRAIN];
  end

  // ---------------------------------------------------------------------------
  // Derived values
  // ---------------------------------------------------------------------------
  // Priority in force: promoted only while this reference is the active one
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      effective_prio <= '0;
    end else begin
      effective_prio <= ref_active ? cfg.promoted_prio : cfg.select_prio;
    end
  end

  // Actual divide ratios are one above the stored values
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      input_ratio    <= '0;
      feedback_ratio <= '0;
    end else begin
      input_ratio    <= {1'b0, cfg.input_div} + 1'b1;
      feedback_ratio <= {1'b0, cfg.feedback_int} + 1'b1;
    end
  end

  // Misprogramming flags; the bank stores the values regardless, so the
  // consumer decides whether to act on a bad profile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      prio_order_bad     <= 1'b0;
      feedback_too_small <= 1'b0;
    end else begin
      prio_order_bad     <= cfg.promoted_prio > cfg.select_prio;
      feedback_too_small <= cfg.feedback_int < profile_cfg_pkg::SDIV_MIN;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  ack_pulse_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack held longer than one cycle");

  ack_latency_a: assert property (req_live && !wb_rsp.ack |=> wb_rsp.ack)
    else $error("request not answered in one cycle");

  select_write_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_PRIO |=>
      cfg.select_prio == $past(wb_req.dat[profile_cfg_pkg::PRIO_W-1:0]))
    else $error("selection priority not stored");

  // Sampled rst_n keeps the first edge after release out of these checks
  promoted_use_a: assert property (
    rst_n && ref_active |=> effective_prio == $past(cfg.promoted_prio))
    else $error("active reference not using promoted priority");

  idle_prio_a: assert property (
    rst_n && !ref_active |=> effective_prio == $past(cfg.select_prio))
    else $error("idle reference not using selection priority");

  period_top_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_PERIOD_TOP |=>
      cfg.period_fs[39:32] == $past(wb_req.dat[7:0]))
    else $error("period top byte misplaced");

  timer_high_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_VALID_TOP |=>
      cfg.validation_ms[15:8] == $past(wb_req.dat[7:0]))
    else $error("validation timer high byte misplaced");

  // Derived flops still hold reset values one edge after release
  input_ratio_a: assert property (
    rst_n |=> input_ratio == {1'b0, $past(cfg.input_div)} + 1'b1)
    else $error("input ratio not value plus one");

  fb_floor_a: assert property (
    rst_n && cfg.feedback_int < profile_cfg_pkg::SDIV_MIN |=> feedback_too_small)
    else $error("short feedback divider not flagged");

  pad_zero_a: assert property (
    wb_rsp.ack && !wb_req.we && req_idx == profile_cfg_pkg::OFF_PAD_LO |->
      wb_rsp.dat == '0)
    else $error("pad byte reads nonzero");

  nibble_zero_a: assert property (
    wb_rsp.ack && !wb_req.we && req_idx == profile_cfg_pkg::OFF_SDIV_TOP |->
      wb_rsp.dat[7:4] == 4'h0)
    else $error("unused divider bits read nonzero");

  fill_write_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_FFILL |=>
      cfg.freq_fill == $past(wb_req.dat[7:0]) ##1 cfg.freq_fill == $past(cfg.freq_fill))
    else $error("frequency fill rate not stored");

  // Feedback ratio follows the stored value
  fb_ratio_a: assert property (
    rst_n |=> feedback_ratio == {1'b0, $past(cfg.feedback_int)} + 1'b1)
    else $error("feedback ratio not value plus one");

  // Flag tracks an illegal priority order
  order_flag_a: assert property (
    rst_n |=> prio_order_bad == ($past(cfg.promoted_prio) > $past(cfg.select_prio)))
    else $error("priority order flag wrong");

  // Read data stands only in the ack cycle
  read_idle_a: assert property (
    !wb_rsp.ack |-> wb_rsp.dat == '0)
    else $error("read data outside ack cycle");

  // Low threshold byte lands in the low bits
  plock_write_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_PLOCK |=>
      cfg.phase_thresh_ps[7:0] == $past(wb_req.dat[7:0]))
    else $error("phase lock threshold low byte misplaced");

  drain_write_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_PDRAIN |=>
      cfg.phase_drain == $past(wb_req.dat[7:0]))
    else $error("phase drain rate not stored");

  // Top divider byte keeps only its six used bits
  rdiv_top_a: assert property (
    wr_fire && req_idx == profile_cfg_pkg::OFF_RDIV_TOP |=>
      cfg.input_div[29:24] == $past(wb_req.dat[5:0]))
    else $error("input divider top bits misplaced");

  write_cov_c: cover property (wr_fire ##2 req_live && !wb_req.we ##1 wb_rsp.ack);
  active_cov_c: cover property (!ref_active ##1 ref_active ##1 effective_prio != $past(effective_prio));
  fb_small_cov_c: cover property ($rose(feedback_too_small));
  unmapped_cov_c: cover property (wb_rsp.ack && !mapped);
  prio_bad_cov_c: cover property ($rose(prio_order_bad));

endmodule

//--- test/reference_profile_config_bank_tb_top.sv
// Self-checking bench for the reference profile configuration bank
`timescale 1ns/10ps
module reference_profile_config_bank_tb_top;
  logic                           sys_clk;
  logic                           rst_n;
  logic                           ref_active;
  profile_cfg_pkg::wb_req_t       wb_req;
  profile_cfg_pkg::wb_rsp_t       wb_rsp;
  profile_cfg_pkg::profile_cfg_t  cfg;
  logic [2:0]                     effective_prio;
  logic [30:0]                    input_ratio;
  logic [20:0]                    feedback_ratio;
  logic                           prio_order_bad;
  logic                           feedback_too_small;
  logic [21:0]                    prog [41];
  profile_cfg_pkg::byte_t         q;
  int                             n_mismatch;
  int                             n_tests;

  reference_profile_config_bank reference_profile_config_bank_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .ref_active(ref_active), .cfg(cfg), .effective_prio(effective_prio),
    .input_ratio(input_ratio), .feedback_ratio(feedback_ratio),
    .prio_order_bad(prio_order_bad), .feedback_too_small(feedback_too_small));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; bounded wait so a missing ack cannot hang the run
  task automatic xfer(input logic we, input logic [13:0] idx, input logic [7:0] d);
    int k;
    @(posedge sys_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'h1,
                dat: {24'h000000, d}};
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_rsp.ack !== 1'b1 && k < 20);
    if (wb_rsp.ack !== 1'b1) begin
      n_mismatch++;
      summarize();
    end
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask

  task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(q, exp);
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    ref_active = 1'b0;
    wb_req = '0;
    n_mismatch = 0;
    n_tests = 0;
    prog = '{{14'h0632, 8'h1a}, {14'h0633, 8'h01}, {14'h0634, 8'h02}, {14'h0635, 8'h03},
             {14'h0636, 8'h04}, {14'h0637, 8'h05}, {14'h0638, 8'hff}, {14'h0640, 8'h34},
             {14'h0641, 8'h12}, {14'h0646, 8'hc5}, {14'h0647, 8'h01}, {14'h0650, 8'hff},
             {14'h0651, 8'hff}, {14'h0652, 8'hff}, {14'h0653, 8'hff}, {14'h0654, 8'h07},
             {14'h0656, 8'hf0}, {14'h065b, 8'hcd}, {14'h065c, 8'hab}, {14'h065d, 8'h11},
             {14'h065e, 8'h22}, {14'h065f, 8'h01}, {14'h0660, 8'h02}, {14'h0661, 8'h03},
             {14'h0662, 8'h33}, {14'h0663, 8'h44}, {14'h0664, 8'hff}, {14'h063a, 8'h11},
             {14'h063b, 8'h22}, {14'h063c, 8'hf3}, {14'h0644, 8'h34}, {14'h0645, 8'h12},
             {14'h064a, 8'h78}, {14'h064b, 8'h56}, {14'h064c, 8'hab}, {14'h064d, 8'h9a},
             {14'h064e, 8'hbc}, {14'h064f, 8'he5}, {14'h0658, 8'h34}, {14'h0659, 8'h5e},
             {14'h065a, 8'hc7}};
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(input_ratio, 31'h00000001);
    check(feedback_too_small, 1'b1);
    rd(14'h0632, 8'h00);
    // Program every field except outer tolerance, redetect timer, beta1, beta0 bits 16:7 and feedback bits 15:8, then derived outputs settle two cycles later
    foreach (prog[i]) xfer(1'b1, prog[i][21:8], prog[i][7:0]);
    repeat (2) @(posedge sys_clk);
    check(cfg.promoted_prio, 3'h3);
    check(cfg.select_prio, 3'h2);
    check(effective_prio, 3'h2);
    check(prio_order_bad, 1'b1);
    check(cfg.period_fs, 40'h0504030201);
    check(cfg.validation_ms, 16'h1234);
    check(cfg.redetect_ms, 16'h0000);
    check(cfg.alpha1_exp, 6'h05);
    check(cfg.alpha2_exp, 3'h7);
    check(cfg.beta0_lin, 17'h00000);
    check(cfg.input_div, 30'h3fffffff);
    check(input_ratio, 31'h40000000);
    check(feedback_ratio, 21'h000008);
    check(feedback_too_small, 1'b0);
    check(cfg.phase_thresh_ps, 16'habcd);
    check(cfg.freq_thresh, 24'h030201);
    check({cfg.phase_fill, cfg.phase_drain}, 16'h1122);
    check({cfg.freq_fill, cfg.freq_drain}, 16'h3344);
    check(cfg.inner_tol, 20'h32211);
    check(cfg.alpha0_lin, 16'h1234);
    check({cfg.alpha3_exp, cfg.delta1_exp}, 9'h1cb);
    check({cfg.gamma1_exp, cfg.gamma0_lin}, 22'h2b5678);
    check(cfg.delta0_lin, 15'h3c9a);
    check({cfg.frac_num, cfg.frac_den}, 20'h1d634);
    // Read-back of masked, pad and unmapped bytes
    rd(14'h0632, 8'h1a);
    rd(14'h0637, 8'h05);
    rd(14'h0638, 8'h00);
    rd(14'h0653, 8'h3f);
    rd(14'h0656, 8'h00);
    rd(14'h0664, 8'h00);
    // Promotion takes over only while the reference is active
    @(posedge sys_clk);
    ref_active <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check(effective_prio, 3'h3);
    ref_active <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(effective_prio, 3'h2);
    // Legal ordering and the largest ratio below the floor
    xfer(1'b1, 14'h0632, 8'h13);
    xfer(1'b1, 14'h0654, 8'h06);
    repeat (2) @(posedge sys_clk);
    check(prio_order_bad, 1'b0);
    check(feedback_ratio, 21'h000007);
    check(feedback_too_small, 1'b1);
    summarize();
  end
endmodule
